// *** verilog/smr_pkg.sv ***
// package: constants for the mode register and dll-off control block
package smr_pkg;

    // ====================================================================
    // pin widths
    localparam int ADDR_W = 13;
    localparam int BA_W   = 3;
    localparam int LAT_W  = 5;

    // ====================================================================
    // command encodings, {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ  = 4'h5;
    localparam logic [3:0] CMD_NOP   = 4'h7;

    // bank address selecting each mode register
    localparam logic [BA_W-1:0] BA_MR0 = 3'h0;
    localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
    localparam logic [BA_W-1:0] BA_MR2 = 3'h2;
    localparam logic [BA_W-1:0] BA_MR3 = 3'h3;

    // ====================================================================
    // mode register field positions
    localparam int MR0_CL_LSB   = 4;
    localparam int MR0_CL_MSB   = 6;
    localparam int MR0_DLL_RST  = 8;
    localparam int MR1_DLL_OFF  = 0;
    localparam int MR1_AL_LSB   = 3;
    localparam int MR1_AL_MSB   = 4;
    localparam int MR1_WLVL     = 7;
    localparam int MR2_CWL_LSB  = 3;
    localparam int MR2_CWL_MSB  = 5;
    localparam int MR2_ASR      = 6;
    localparam int MR2_SRT      = 7;
    localparam int MR2_RTT_LSB  = 9;
    localparam int MR2_RTT_MSB  = 10;
    localparam int MR3_LOC_LSB  = 0;
    localparam int MR3_LOC_MSB  = 1;
    localparam int MR3_MPR      = 2;

    // latency field codes
    localparam logic [LAT_W-1:0] CL_BASE  = 5'h04;
    localparam logic [LAT_W-1:0] CWL_BASE = 5'h05;
    localparam logic [1:0]       AL_OFF   = 2'h0;
    localparam logic [1:0]       AL_CL_M1 = 2'h1;
    localparam logic [1:0]       AL_CL_M2 = 2'h2;
    localparam logic [LAT_W-1:0] LAT_ONE  = 5'h01;
    localparam logic [LAT_W-1:0] LAT_TWO  = 5'h02;
    localparam logic [LAT_W-1:0] DLL_OFF_CL  = 5'h06;
    localparam logic [LAT_W-1:0] DLL_OFF_CWL = 5'h06;

    // ====================================================================
    // register port map, byte addresses
    localparam int REG_AW = 4;
    localparam logic [REG_AW-1:0] OFF_CTRL   = 4'h0;
    localparam logic [REG_AW-1:0] OFF_STATUS = 4'h4;
    localparam logic [REG_AW-1:0] OFF_LAT    = 4'h8;
    localparam logic [REG_AW-1:0] OFF_MODE   = 4'hC;

    // control bits
    localparam int CTRL_HOT     = 0;
    localparam int CTRL_LATCLR  = 1;
    // status bits
    localparam int ST_DLL_OFF   = 0;
    localparam int ST_MPR       = 1;
    localparam int ST_WLVL      = 2;
    localparam int ST_ASR       = 3;
    localparam int ST_SRT       = 4;
    localparam int ST_SR_FAST   = 5;
    localparam int ST_LAT_ERR   = 6;
    // latency register fields
    localparam int LAT_CL_LSB   = 0;
    localparam int LAT_CWL_LSB  = 8;
    localparam int LAT_AL_LSB   = 16;
    localparam int LAT_WL_LSB   = 24;
    // mode register fields
    localparam int MODE_RTT_LSB = 0;
    localparam int MODE_LOC_LSB = 4;
    localparam int MODE_RL_LSB  = 8;

endpackage

// *** verilog/smr_sync.sv ***
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none

module smr_sync
#(
    parameter int W = 1
)
(
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            meta <= '0;
            q_o  <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule
`default_nettype wire

// *** verilog/smr_mode_ctl.sv ***
// mode register decode, latency timing and dll-off control of the memory
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: cas write latency from MR2 A5..A3
// R2: write latency is additive plus cas write
// R3: asr clear: srt bit picks refresh rate
// R4: asr set: thermal sensor picks refresh rate
// R5: dynamic write termination from MR2 A10..A9
// R6: write leveling disables dynamic write termination
// R7: MRS with bank three writes MR3
// R8: controller zeroes reserved MR3 bits
// R9: pattern select ignored while mpr off
// R10: controller enables mpr from idle banks
// R11: reads under mpr return calibration pattern
// R12: controller issues only reads under mpr
// R13: nop registers no new command
// R14: deselect executes no new command
// R15: MR1 A0 turns dll off until cleared
// R16: dll-off needs cl six, cwl six
// R17: dll-off read window starts one earlier
// R18: controller dll-off sequence via self refresh
// R19: controller holds cke, odt after exit
// R20: controller dll-on sequence via self refresh
// R21: controller resets dll, reprograms latencies
// R22: controller holds cke, odt until locked
// R23: controller waits lock before dll commands
// R24: dll reset bit clears itself
// R25: additive latency decode from MR1 A4..A3
module smr_mode_ctl
#(
    parameter int PIPE_DEPTH = 32
)
(
    input  wire logic                          ref_clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          ck_i,
    input  wire logic                          mem_rst_n_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          ras_n_i,
    input  wire logic                          cas_n_i,
    input  wire logic                          we_n_i,
    input  wire logic [smr_pkg::BA_W-1:0]      ba_i,
    input  wire logic [smr_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [smr_pkg::REG_AW-1:0]    reg_addr_i,
    input  wire logic [31:0]                   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [31:0]                   reg_rdata_o,
    output logic                               rd_dqs_start_o,
    output logic                               rd_mpr_start_o,
    output logic                               wr_data_start_o,
    output logic                               dll_off_o,
    output logic                               dll_reset_o,
    output logic                               mpr_en_o,
    output logic      [1:0]                    mpr_loc_o,
    output logic      [1:0]                    rtt_wr_o,
    output logic                               sr_fast_o,
    output logic      [smr_pkg::LAT_W-1:0]     rl_o,
    output logic      [smr_pkg::LAT_W-1:0]     wl_o
);
    import smr_pkg::*;

    // ====================================================================
    // pin synchronisation and command clock edge
    localparam int PIN_W = 6 + BA_W + ADDR_W;

    logic [PIN_W-1:0]  pins_s;
    logic              ck_s;
    logic              ck_d;
    logic              mrst_n_s;
    logic [3:0]        cmd;
    logic [BA_W-1:0]   ba_s;
    logic [ADDR_W-1:0] a_s;
    logic              ck_edge;

    smr_sync #(.W(PIN_W)) u_pin_sync
    (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .d_i       ({ck_i, mem_rst_n_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
                     ba_i, addr_i}),
        .q_o       (pins_s)
    );

    assign {ck_s, mrst_n_s, cmd, ba_s, a_s} = pins_s;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            ck_d <= 1'b0;
        else
            ck_d <= ck_s;
    end

    assign ck_edge = ck_s & ~ck_d;

    // ====================================================================
    // command decode; nop and deselect fall through with no effect
    logic is_mrs;
    logic is_rd;
    logic is_wr;

    assign is_mrs = ck_edge && (cmd == CMD_MRS);  // R13 R14
    assign is_rd  = ck_edge && (cmd == CMD_READ);
    assign is_wr  = ck_edge && (cmd == CMD_WRITE);

    // ====================================================================
    // mode register fields
    logic [2:0] cl_code;
    logic       dll_off;
    logic [1:0] al_code;
    logic       wlvl;
    logic [2:0] cwl_code;
    logic       asr;
    logic       srt;
    logic [1:0] rtt_wr;
    logic       mpr_en;
    logic [1:0] mpr_loc;
    logic       dll_rst;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cl_code <= '0;
            dll_off <= 1'b0;
            al_code <= '0;
            wlvl    <= 1'b0;
        end
        else if (!mrst_n_s)
        begin
            cl_code <= '0;
            dll_off <= 1'b0;
            al_code <= '0;
            wlvl    <= 1'b0;
        end
        else if (is_mrs && ba_s == BA_MR0)
            cl_code <= a_s[MR0_CL_MSB:MR0_CL_LSB];
        else if (is_mrs && ba_s == BA_MR1)
        begin
            dll_off <= a_s[MR1_DLL_OFF];  // R15
            al_code <= a_s[MR1_AL_MSB:MR1_AL_LSB];
            wlvl    <= a_s[MR1_WLVL];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cwl_code <= '0;
            asr      <= 1'b0;
            srt      <= 1'b0;
            rtt_wr   <= '0;
        end
        else if (!mrst_n_s)
        begin
            cwl_code <= '0;
            asr      <= 1'b0;
            srt      <= 1'b0;
            rtt_wr   <= '0;
        end
        else if (is_mrs && ba_s == BA_MR2)
        begin
            cwl_code <= a_s[MR2_CWL_MSB:MR2_CWL_LSB];  // R1
            asr      <= a_s[MR2_ASR];
            srt      <= a_s[MR2_SRT];
            rtt_wr   <= a_s[MR2_RTT_MSB:MR2_RTT_LSB];  // R5
        end
    end

    // reserved MR3 bits are not stored, so a stray one does no harm
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mpr_en  <= 1'b0;
            mpr_loc <= '0;
        end
        else if (!mrst_n_s)
        begin
            mpr_en  <= 1'b0;
            mpr_loc <= '0;
        end
        else if (is_mrs && ba_s == BA_MR3)  // R7 R8
        begin
            mpr_en  <= a_s[MR3_MPR];  // R10
            mpr_loc <= a_s[MR3_LOC_MSB:MR3_LOC_LSB];
        end
    end

    // dll reset request lives for one command clock cycle only
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            dll_rst <= 1'b0;
        else if (!mrst_n_s)
            dll_rst <= 1'b0;
        else if (is_mrs && ba_s == BA_MR0)
            dll_rst <= a_s[MR0_DLL_RST];
        else if (ck_edge)
            dll_rst <= 1'b0;  // R24
    end

    // ====================================================================
    // latency arithmetic
    logic [LAT_W-1:0] cl;
    logic [LAT_W-1:0] cwl;
    logic [LAT_W-1:0] al;
    logic [LAT_W-1:0] next_rl;
    logic [LAT_W-1:0] next_wl;

    assign cl  = CL_BASE + LAT_W'(cl_code);
    assign cwl = CWL_BASE + LAT_W'(cwl_code);

    always_comb
    begin
        unique case (al_code)  // R25
            AL_CL_M1: al = cl - LAT_ONE;
            AL_CL_M2: al = cl - LAT_TWO;
            default:  al = '0;
        endcase
    end

    // whole clocks only, so one sum per latency
    assign next_wl = al + cwl;  // R2
    assign next_rl = dll_off ? (al + cl - LAT_ONE) : (al + cl);  // R17

    // ====================================================================
    // latency pipes advanced on each command clock edge
    logic [PIPE_DEPTH-1:0] rd_pipe;
    logic [PIPE_DEPTH-1:0] mpr_pipe;
    logic [PIPE_DEPTH-1:0] wr_pipe;
    logic                  rd_hit;
    logic                  mpr_hit;
    logic                  wr_hit;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_pipe  <= '0;
            mpr_pipe <= '0;
            wr_pipe  <= '0;
        end
        else if (ck_edge)
        begin
            rd_pipe  <= {rd_pipe[PIPE_DEPTH-2:0], is_rd};
            mpr_pipe <= {mpr_pipe[PIPE_DEPTH-2:0], is_rd & mpr_en};  // R11
            wr_pipe  <= {wr_pipe[PIPE_DEPTH-2:0], is_wr};
        end
    end

    // a tap of zero cannot occur: latencies are at least three
    assign rd_hit  = ck_edge && rd_pipe[rl_o - LAT_ONE];
    assign mpr_hit = ck_edge && mpr_pipe[rl_o - LAT_ONE];
    assign wr_hit  = ck_edge && wr_pipe[wl_o - LAT_ONE];

    // ====================================================================
    // outputs
    logic thermal_hot;

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_dqs_start_o  <= 1'b0;
            rd_mpr_start_o  <= 1'b0;
            wr_data_start_o <= 1'b0;
        end
        else
        begin
            rd_dqs_start_o  <= rd_hit;  // R17
            rd_mpr_start_o  <= mpr_hit;  // R11
            wr_data_start_o <= wr_hit;  // R1
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dll_off_o   <= 1'b0;
            dll_reset_o <= 1'b0;
            mpr_en_o    <= 1'b0;
            mpr_loc_o   <= '0;
            rtt_wr_o    <= '0;
            sr_fast_o   <= 1'b0;
            rl_o        <= CL_BASE;
            wl_o        <= CWL_BASE;
        end
        else
        begin
            dll_off_o   <= dll_off;  // R15
            dll_reset_o <= dll_rst & ck_edge;  // R24
            mpr_en_o    <= mpr_en;
            mpr_loc_o   <= mpr_en ? mpr_loc : 2'h0;  // R9
            rtt_wr_o    <= wlvl ? 2'h0 : rtt_wr;  // R5 R6
            sr_fast_o   <= asr ? thermal_hot : srt;  // R3 R4
            rl_o        <= next_rl;
            wl_o        <= next_wl;  // R2
        end
    end

    // ====================================================================
    // register port
    logic lat_err;
    logic lat_clr;

    assign lat_clr = reg_wr_i && reg_addr_i == OFF_CTRL
                     && reg_wdata_i[CTRL_LATCLR];

    // thermal reading is supplied by software on behalf of the sensor
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            thermal_hot <= 1'b0;
        else if (reg_wr_i && reg_addr_i == OFF_CTRL)
            thermal_hot <= reg_wdata_i[CTRL_HOT];
    end

    // sticky: dll-off with latencies the block cannot honour; set wins
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            lat_err <= 1'b0;
        else if (dll_off && (cl != DLL_OFF_CL || cwl != DLL_OFF_CWL))
            lat_err <= 1'b1;  // R16
        else if (lat_clr)
            lat_err <= 1'b0;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= '0;
        else if (!reg_rd_i)
            reg_rdata_o <= '0;
        else
        begin
            reg_rdata_o <= '0;
            unique case (reg_addr_i)
                OFF_CTRL:
                    reg_rdata_o[CTRL_HOT] <= thermal_hot;
                OFF_STATUS:
                begin
                    reg_rdata_o[ST_DLL_OFF] <= dll_off;
                    reg_rdata_o[ST_MPR]     <= mpr_en;
                    reg_rdata_o[ST_WLVL]    <= wlvl;
                    reg_rdata_o[ST_ASR]     <= asr;
                    reg_rdata_o[ST_SRT]     <= srt;
                    reg_rdata_o[ST_SR_FAST] <= sr_fast_o;
                    reg_rdata_o[ST_LAT_ERR] <= lat_err;
                end
                OFF_LAT:
                begin
                    reg_rdata_o[LAT_CL_LSB +: LAT_W]  <= cl;
                    reg_rdata_o[LAT_CWL_LSB +: LAT_W] <= cwl;
                    reg_rdata_o[LAT_AL_LSB +: LAT_W]  <= al;
                    reg_rdata_o[LAT_WL_LSB +: LAT_W]  <= wl_o;
                end
                OFF_MODE:
                begin
                    reg_rdata_o[MODE_RTT_LSB +: 2]    <= rtt_wr_o;
                    reg_rdata_o[MODE_LOC_LSB +: 2]    <= mpr_loc_o;
                    reg_rdata_o[MODE_RL_LSB +: LAT_W] <= rl_o;
                end
                default:
                    reg_rdata_o <= '0;
            endcase
        end
    end

    // ====================================================================
    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_dll_reset_pulse: assert property  // R24
        (dll_reset_o |=> !dll_reset_o)
        else $error("dll reset not self clearing");

    chk_mr3_write: assert property  // R7
        (is_mrs && ba_s == BA_MR3 && mrst_n_s
         |=> ##1 mpr_en_o == $past(a_s[MR3_MPR], 2))
        else $error("MR3 write did not reach mpr enable");

    chk_mpr_loc_ignored: assert property  // R9
        (!mpr_en_o |-> mpr_loc_o == 2'h0)
        else $error("pattern select visible with mpr off");

    chk_wlvl_no_rtt: assert property  // R6
        ($past(wlvl) |-> rtt_wr_o == 2'h0)
        else $error("dynamic termination during write leveling");

    chk_wl_sum: assert property  // R2
        (wl_o == $past(al) + $past(cwl))
        else $error("write latency not al plus cwl");

    chk_sr_sensor: assert property  // R4
        ($past(asr) |-> sr_fast_o == $past(thermal_hot))
        else $error("asr rate not from sensor");

    chk_sr_srt: assert property  // R3
        (!$past(asr) |-> sr_fast_o == $past(srt))
        else $error("refresh rate not from srt");

    chk_dll_off_rl: assert property  // R17
        ($past(dll_off) |-> rl_o == $past(al) + $past(cl) - LAT_ONE)
        else $error("dll-off read latency not one earlier");

    chk_nop_idle: assert property  // R13
        (ck_edge && cmd == CMD_NOP && mrst_n_s
         |=> $stable(cl_code) && $stable(dll_off) && $stable(mpr_en))
        else $error("nop changed a mode register");

    chk_deselect_idle: assert property  // R14
        (ck_edge && cmd[3] && mrst_n_s
         |=> $stable(cwl_code) && $stable(rtt_wr))
        else $error("deselect changed a mode register");

    chk_mpr_read: assert property  // R11
        (rd_mpr_start_o |-> rd_dqs_start_o && mpr_en_o)
        else $error("pattern read outside read window");

    chk_dll_off_latch: assert property  // R15
        (is_mrs && ba_s == BA_MR1 && mrst_n_s
         |=> dll_off == $past(a_s[MR1_DLL_OFF]))
        else $error("dll off bit not taken");

    cov_mpr_read: cover property (rd_mpr_start_o);
    cov_dll_off_read: cover property (dll_off_o && rd_dqs_start_o);
    cov_write_start: cover property (wr_data_start_o);
    cov_dll_reset: cover property (dll_reset_o);

endmodule
`default_nettype wire

// *** tb/smr_ctl_model.sv ***
// controller-side model: makes the memory clock and drives commands
`timescale 1ns/10ps
`default_nettype none

module smr_ctl_model
(
    input  wire logic                  ref_clk_i,
    output logic                       ck_o,
    output logic                       cs_n_o,
    output logic                       ras_n_o,
    output logic                       cas_n_o,
    output logic                       we_n_o,
    output logic [smr_pkg::BA_W-1:0]   ba_o,
    output logic [smr_pkg::ADDR_W-1:0] addr_o
);
    import smr_pkg::*;

    logic [2:0] cnt = 3'h0;

    // ====================================================================
    // memory clock, 8 ref cycles a period
    // runs free: the memory wants a stable clock in normal operation
    always @(posedge ref_clk_i)
        cnt <= cnt + 3'h1;
    assign ck_o = cnt[2];

    initial
    begin
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
        ba_o = 3'h0;
        addr_o = 13'h0000;
    end

    // ====================================================================
    // one command, changed on falling ck so it sits still around the rise
    task automatic issue(input logic [3:0] c, input logic [BA_W-1:0] b,
                         input logic [ADDR_W-1:0] a);
        @(negedge ck_o);
        {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
        ba_o <= b;
        addr_o <= (b == BA_MR3) ? (a & 13'h0007) : a;
        @(negedge ck_o);
        // released lines show a moving pattern, never the old command
        cs_n_o <= 1'b1;
        {ras_n_o, cas_n_o, we_n_o} <= ~{ras_n_o, cas_n_o, we_n_o};
        ba_o <= ~ba_o;
        addr_o <= ~addr_o;
    endtask
endmodule
`default_nettype wire

// *** tb/smr_mode_ctl_tb_top.sv ***
// self-checking bench for the mode register and dll-off control block
`timescale 1ns/10ps
`default_nettype none

module smr_mode_ctl_tb_top;
    import smr_pkg::*;

    typedef struct packed {
        logic [3:0]        cmd;
        logic [BA_W-1:0]   ba;
        logic [ADDR_W-1:0] addr;
        logic [16:0]       exp;
    } smr_row_t;

    logic              ref_clk;
    logic              nrst;
    logic              mem_rst_n;
    logic              ck;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
    logic [REG_AW-1:0] reg_addr;
    logic [31:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [31:0]       reg_rdata;
    logic              rd_dqs;
    logic              rd_mpr;
    logic              wr_start;
    logic              dll_off;
    logic              dll_rst;
    logic              mpr_en;
    logic [1:0]        loc;
    logic [1:0]        rtt;
    logic              sr_fast;
    logic [LAT_W-1:0]  rl;
    logic [LAT_W-1:0]  wl;
    int                fail_count = 0;
    int                n_checks = 0;

    // expected: {rl, wl, dll_off, mpr, loc, rtt, sr_fast}
    smr_row_t rows [0:11] = '{
        '{CMD_MRS, BA_MR0, 13'h0020, {5'h06, 5'h05, 7'h00}},
        '{CMD_MRS, BA_MR2, 13'h0288, {5'h06, 5'h06, 7'h03}},
        '{CMD_MRS, BA_MR1, 13'h0008, {5'h0B, 5'h0B, 7'h03}},
        '{CMD_MRS, BA_MR1, 13'h0090, {5'h0A, 5'h0A, 7'h01}},
        '{CMD_MRS, BA_MR1, 13'h0001, {5'h05, 5'h06, 7'h43}},
        '{CMD_MRS, BA_MR3, 13'h0003, {5'h05, 5'h06, 7'h43}},
        '{CMD_MRS, BA_MR3, 13'h0006, {5'h05, 5'h06, 7'h73}},
        '{CMD_MRS, BA_MR2, 13'h0448, {5'h05, 5'h06, 7'h74}},
        '{CMD_NOP, BA_MR0, 13'h0070, {5'h05, 5'h06, 7'h74}},
        '{4'h8,    BA_MR0, 13'h0070, {5'h05, 5'h06, 7'h74}},
        '{CMD_MRS, BA_MR3, 13'h0000, {5'h05, 5'h06, 7'h44}},
        '{CMD_MRS, BA_MR1, 13'h0000, {5'h06, 5'h06, 7'h04}}
    };

    smr_mode_ctl uut (.ref_clk_i(ref_clk), .nrst_i(nrst), .ck_i(ck),
        .mem_rst_n_i(mem_rst_n), .cs_n_i(cs_n), .ras_n_i(ras_n),
        .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .rd_dqs_start_o(rd_dqs),
        .rd_mpr_start_o(rd_mpr), .wr_data_start_o(wr_start),
        .dll_off_o(dll_off), .dll_reset_o(dll_rst), .mpr_en_o(mpr_en),
        .mpr_loc_o(loc), .rtt_wr_o(rtt), .sr_fast_o(sr_fast), .rl_o(rl),
        .wl_o(wl));

    smr_ctl_model ctl (.ref_clk_i(ref_clk), .ck_o(ck), .cs_n_o(cs_n),
        .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba),
        .addr_o(addr));

    // ====================================================================
    // helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic cmd(input logic [3:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a);
        ctl.issue(c, b, a);
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [REG_AW-1:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", e, reg_rdata);
    endtask

    // counts ck rises from the command edge to the start pulse
    task automatic lat(input logic [3:0] c, input logic [4:0] e,
                       input logic m);
        int   n;
        logic q;
        logic seen;
        n = 0;
        q = 1'b0;
        seen = 1'b0;
        ctl.issue(c, BA_MR0, 13'h0000);
        for (int k = 0; k < 400; k++)
        begin
            @(posedge ref_clk);
            if (ck === 1'b1 && q === 1'b0)
                n++;
            q = ck;
            seen = rd_mpr;
            if ((c == CMD_READ ? rd_dqs : wr_start) === 1'b1)
                break;
        end
        chk("latency", {27'h0, e}, n);
        chk("rd_mpr_start", {31'h0, m}, {31'h0, seen});
    endtask

    // ====================================================================
    // clock, watchdog, sequence
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        int n;
        nrst = 1'b0;
        mem_rst_n = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        foreach (rows[i])
        begin
            cmd(rows[i].cmd, rows[i].ba, rows[i].addr);
            chk("outputs", {15'h0, rows[i].exp},
                {15'h0, rl, wl, dll_off, mpr_en, loc, rtt, sr_fast});
        end
        rd(OFF_STATUS, 32'h00000008);
        wr(OFF_CTRL, 32'h00000001);
        rd(OFF_STATUS, 32'h00000028);
        rd(OFF_LAT, 32'h06000606);
        rd(4'h2, 32'h00000000);
        wr(4'h2, 32'hFFFFFFFF);
        rd(OFF_MODE, 32'h00000602);
        lat(CMD_WRITE, 5'h06, 1'b0);
        cmd(CMD_MRS, BA_MR3, 13'h0004);
        lat(CMD_READ, 5'h06, 1'b1);
        cmd(CMD_MRS, BA_MR3, 13'h0000);
        lat(CMD_READ, 5'h06, 1'b0);
        cmd(CMD_MRS, BA_MR1, 13'h0001);
        lat(CMD_READ, 5'h05, 1'b0);
        cmd(CMD_MRS, BA_MR0, 13'h0030);
        rd(OFF_STATUS, 32'h00000069);
        ctl.issue(CMD_MRS, BA_MR0, 13'h0130);
        n = 0;
        repeat (24)
        begin
            @(posedge ref_clk);
            if (dll_rst === 1'b1)
                n++;
        end
        chk("dll_reset pulses", 32'h1, n);
        mem_rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        mem_rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk("after mem reset", {15'h0, 5'h04, 5'h05, 7'h00},
            {15'h0, rl, wl, dll_off, mpr_en, loc, rtt, sr_fast});
        // latency error stays set after the cause is gone until cleared
        rd(OFF_STATUS, 32'h00000040);
        wr(OFF_CTRL, 32'h00000003);
        rd(OFF_STATUS, 32'h00000000);
        rd(OFF_CTRL, 32'h00000001);
        report_and_stop();
    end
endmodule
`default_nettype wire
